// *** core/spfs_pkg.sv ***
// constants and types shared by the shared pin function select block
package spfs_pkg;
  localparam int unsigned GP_W          = 16;
  localparam int unsigned GP_CLK4_BIT   = 1;
  localparam int unsigned GP_CLK6_BIT   = 2;
  localparam int unsigned GP_DAC_BIT    = 8;
  localparam int unsigned GP_PBUS_LSB   = 9;
  localparam int unsigned GP_PBUS_MSB   = 15;
  localparam int unsigned CLK_PIN_W     = 2;
  localparam int unsigned PBUS_SHARED_W = GP_PBUS_MSB - GP_PBUS_LSB + 1;
  localparam int unsigned AV_W          = 8;
  localparam int unsigned PBUS_DED_W    = 8;
  localparam logic        PBUS_EN_RST   = 1'b0;
  localparam logic        OE_OFF        = 1'b0;
  localparam logic [GP_W-1:0] GP_OWNABLE = 16'hff06;

  typedef enum logic [3:0] {
    SPFS_FILL0  = 4'h1,
    SPFS_FILL1  = 4'h2,
    SPFS_SAMPLE = 4'h4,
    SPFS_LOCK   = 4'h8
  } spfs_strap_e;
endpackage : spfs_pkg

// *** core/spfs_cfg_if.sv ***
// carries the latched parallel bus selection from the strap capture to the pin mux
`timescale 1ns/100ps
interface spfs_cfg_if;
  logic pbus_en;
  logic locked;
  modport src (output pbus_en, output locked);
  modport snk (input pbus_en, input locked);
endinterface : spfs_cfg_if

// *** core/spfs_strap_capture.sv ***
// synchronises the parallel bus strap pin and latches it once after reset
`timescale 1ns/100ps
module spfs_strap_capture
  import spfs_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic strap_in,
  spfs_cfg_if.src   cfg
);
  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic        en;
    spfs_strap_e st;
  } spfs_cap_s;

  spfs_cap_s q;
  spfs_cap_s d;

  always_comb begin
    d       = q;
    d.sync1 = strap_in;
    d.sync2 = q.sync1;
    unique case (q.st)
      SPFS_FILL0:  d.st = SPFS_FILL1;
      SPFS_FILL1:  d.st = SPFS_SAMPLE;
      SPFS_SAMPLE: begin
        d.en = q.sync2;
        d.st = SPFS_LOCK;
      end
      SPFS_LOCK:   d.st = SPFS_LOCK;
      default:     d.st = SPFS_FILL0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '{sync1: 1'b0, sync2: 1'b0, en: PBUS_EN_RST, st: SPFS_FILL0};
    end else begin
      q <= d;
    end
  end

  assign cfg.pbus_en = q.en;
  assign cfg.locked  = (q.st == SPFS_LOCK);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_STRAP_FROZEN: assert property (q.st == SPFS_LOCK |=> $stable(q.en) && q.st == SPFS_LOCK)
    else $error("strap selection changed after lock");
  AST_STRAP_SAMPLED: assert property (q.st == SPFS_SAMPLE |=> q.en == $past(q.sync2))
    else $error("strap not taken from synchroniser");
endmodule : spfs_strap_capture

// *** core/spfs_pin_select.sv ***
// shared pin function select: routes peripheral and general io functions onto shared pads
`timescale 1ns/100ps
// Behaviour
// - parallel bus strap is latched once, on the third clock after reset release, and held fixed afterwards.
// - each strap-selected pin has at most one owning peripheral.
// - after reset clock pins drive cpu/4 and cpu/6 with io bits 1,2 off.
// - an io enable bit of 1 gives that pin to general io; bits 8 to 15 only once the strap has locked the bus off.
// - io direction 0 makes an enabled pin input, 1 makes it output.
// - dac pin defaults to dac output, io bit 8 clear.
// - io bit 8 takes dac pin only with parallel bus off and enable set.
// - io bits 9 to 15 claim bus pins only with bus off and enabled.
// - after reset the eight video/audio shared pins have no function.
// - video port 1 enable routes upper video data, audio data off.
// - audio serial 0 enable with video port 1 off routes its eight data lines, video data off.
// - unshared parallel bus pins stay high impedance while that bus is off.
// - strap 0 disables, 1 enables parallel bus over shared functions.
module spfs_pin_select
  import spfs_pkg::*;
(
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     pbus_enable_strap_in,
  input  wire logic [GP_W-1:0]          general_io_pin_enable_in,
  input  wire logic [GP_W-1:0]          general_io_pin_direction_in,
  input  wire logic [GP_W-1:0]          general_io_bank_in,
  output logic      [GP_W-1:0]          general_io_bank_out,
  input  wire logic                     video_port1_enable_in,
  input  wire logic                     audio_serial0_enable_in,
  input  wire logic                     cpu_div4_clock_in,
  input  wire logic                     cpu_div6_clock_in,
  input  wire logic                     video_dac_output_in,
  input  wire logic [PBUS_SHARED_W-1:0] pbus_shared_data_in,
  input  wire logic [PBUS_SHARED_W-1:0] pbus_shared_oe_in,
  output logic      [PBUS_SHARED_W-1:0] pbus_shared_rx_out,
  input  wire logic [PBUS_DED_W-1:0]    pbus_ded_data_in,
  input  wire logic [PBUS_DED_W-1:0]    pbus_ded_oe_in,
  input  wire logic [AV_W-1:0]          video_port1_data_in,
  input  wire logic [AV_W-1:0]          video_port1_data_oe_in,
  output logic      [AV_W-1:0]          video_port1_data_out,
  input  wire logic [AV_W-1:0]          audio_serial0_data_lines_in,
  input  wire logic [AV_W-1:0]          audio_serial0_data_lines_oe_in,
  output logic      [AV_W-1:0]          audio_serial0_data_lines_out,
  input  wire logic [CLK_PIN_W-1:0]     clk_pad_in,
  output logic      [CLK_PIN_W-1:0]     clk_pad_out,
  output logic      [CLK_PIN_W-1:0]     clk_pad_oe_out,
  input  wire logic                     dac_pad_in,
  output logic                          dac_pad_out,
  output logic                          dac_pad_oe_out,
  input  wire logic [PBUS_SHARED_W-1:0] pbus_pad_in,
  output logic      [PBUS_SHARED_W-1:0] pbus_pad_out,
  output logic      [PBUS_SHARED_W-1:0] pbus_pad_oe_out,
  input  wire logic [AV_W-1:0]          av_pad_in,
  output logic      [AV_W-1:0]          av_pad_out,
  output logic      [AV_W-1:0]          av_pad_oe_out,
  output logic      [PBUS_DED_W-1:0]    pbus_ded_pad_out,
  output logic      [PBUS_DED_W-1:0]    pbus_ded_pad_oe_out,
  output logic                          parallel_bus_enabled_out
);
  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [GP_W-1:0]          gp_s1;
    logic [GP_W-1:0]          gp_s2;
    logic [AV_W-1:0]          av_s1;
    logic [AV_W-1:0]          av_s2;
    logic [GP_W-1:0]          gp_rd;
    logic [PBUS_SHARED_W-1:0] pbus_rx;
    logic [AV_W-1:0]          vp_rx;
    logic [AV_W-1:0]          au_rx;
    logic [CLK_PIN_W-1:0]     clk_o;
    logic [CLK_PIN_W-1:0]     clk_oe;
    logic                     dac_o;
    logic                     dac_oe;
    logic [PBUS_SHARED_W-1:0] pb_o;
    logic [PBUS_SHARED_W-1:0] pb_oe;
    logic [AV_W-1:0]          av_o;
    logic [AV_W-1:0]          av_oe;
    logic [PBUS_DED_W-1:0]    ded_o;
    logic [PBUS_DED_W-1:0]    ded_oe;
  } spfs_pin_s;

  spfs_pin_s q;
  spfs_pin_s d;

  spfs_cfg_if cfg ();

  spfs_strap_capture u_strap (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .strap_in (pbus_enable_strap_in),
    .cfg      (cfg.src)
  );

  // gp pad image in bank order; bits with no shared pad read as zero
  function automatic logic [GP_W-1:0] gp_pads(input logic [CLK_PIN_W-1:0] c, input logic dac,
                                               input logic [PBUS_SHARED_W-1:0] pb);
    logic [GP_W-1:0] v;
    v = '0;
    v[GP_CLK4_BIT] = c[0];
    v[GP_CLK6_BIT] = c[1];
    v[GP_DAC_BIT]  = dac;
    v[GP_PBUS_MSB:GP_PBUS_LSB] = pb;
    return v;
  endfunction : gp_pads

  //////////////////////////////////////////////////////////////////////////////
  logic            bus_on;
  logic            gp_free;
  logic            vp_sel;
  logic            au_sel;
  logic [GP_W-1:0] gp_own;
  logic [GP_W-1:0] gp_drv;

  always_comb begin
    // until the strap is locked neither the bus nor bus-shared io may own a pin
    bus_on  = cfg.locked && cfg.pbus_en;
    gp_free = cfg.locked && !cfg.pbus_en;
    vp_sel  = video_port1_enable_in;
    // video wins if software sets both, so the pads never see two drivers
    au_sel  = audio_serial0_enable_in && !video_port1_enable_in;
    gp_own  = general_io_pin_enable_in & GP_OWNABLE;
    gp_own[GP_PBUS_MSB:GP_DAC_BIT] = gp_own[GP_PBUS_MSB:GP_DAC_BIT]
                                     & {(GP_PBUS_MSB-GP_DAC_BIT+1){gp_free}};
    gp_drv  = gp_own & general_io_pin_direction_in;

    d       = q;
    d.gp_s1 = gp_pads(clk_pad_in, dac_pad_in, pbus_pad_in);
    d.gp_s2 = q.gp_s1;
    d.av_s1 = av_pad_in;
    d.av_s2 = q.av_s1;
    d.gp_rd = q.gp_s2 & gp_own & ~general_io_pin_direction_in;

    // clock pins: cpu/4 and cpu/6 unless io owns them
    d.clk_o[0]  = gp_own[GP_CLK4_BIT] ? general_io_bank_in[GP_CLK4_BIT] : cpu_div4_clock_in;
    d.clk_o[1]  = gp_own[GP_CLK6_BIT] ? general_io_bank_in[GP_CLK6_BIT] : cpu_div6_clock_in;
    d.clk_oe[0] = gp_own[GP_CLK4_BIT] ? gp_drv[GP_CLK4_BIT] : 1'b1;
    d.clk_oe[1] = gp_own[GP_CLK6_BIT] ? gp_drv[GP_CLK6_BIT] : 1'b1;

    d.dac_o  = gp_own[GP_DAC_BIT] ? general_io_bank_in[GP_DAC_BIT] : video_dac_output_in;
    d.dac_oe = gp_own[GP_DAC_BIT] ? gp_drv[GP_DAC_BIT] : 1'b1;

    // bus-shared pins: bus, io, or nothing
    if (bus_on) begin
      d.pb_o  = pbus_shared_data_in;
      d.pb_oe = pbus_shared_oe_in;
    end else begin
      d.pb_o  = general_io_bank_in[GP_PBUS_MSB:GP_PBUS_LSB];
      d.pb_oe = gp_drv[GP_PBUS_MSB:GP_PBUS_LSB];
    end
    d.pbus_rx = bus_on ? q.gp_s2[GP_PBUS_MSB:GP_PBUS_LSB] : '0;

    d.ded_o  = bus_on ? pbus_ded_data_in : '0;
    d.ded_oe = bus_on ? pbus_ded_oe_in : {PBUS_DED_W{OE_OFF}};

    if (vp_sel) begin
      d.av_o  = video_port1_data_in;
      d.av_oe = video_port1_data_oe_in;
    end else if (au_sel) begin
      d.av_o  = audio_serial0_data_lines_in;
      d.av_oe = audio_serial0_data_lines_oe_in;
    end else begin
      d.av_o  = '0;
      d.av_oe = {AV_W{OE_OFF}};
    end
    d.vp_rx = vp_sel ? q.av_s2 : '0;
    d.au_rx = au_sel ? q.av_s2 : '0;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q        <= '0;
      q.clk_oe <= {CLK_PIN_W{1'b1}};
      q.dac_oe <= 1'b1;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign general_io_bank_out          = q.gp_rd;
  assign pbus_shared_rx_out           = q.pbus_rx;
  assign video_port1_data_out         = q.vp_rx;
  assign audio_serial0_data_lines_out = q.au_rx;
  assign clk_pad_out                  = q.clk_o;
  assign clk_pad_oe_out               = q.clk_oe;
  assign dac_pad_out                  = q.dac_o;
  assign dac_pad_oe_out               = q.dac_oe;
  assign pbus_pad_out                 = q.pb_o;
  assign pbus_pad_oe_out              = q.pb_oe;
  assign av_pad_out                   = q.av_o;
  assign av_pad_oe_out                = q.av_oe;
  assign pbus_ded_pad_out             = q.ded_o;
  assign pbus_ded_pad_oe_out          = q.ded_oe;
  assign parallel_bus_enabled_out     = cfg.pbus_en;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_CLK4_DEFAULT: assert property (!general_io_pin_enable_in[GP_CLK4_BIT] |=>
      clk_pad_oe_out[0] && clk_pad_out[0] == $past(cpu_div4_clock_in))
    else $error("cpu/4 pin lost its clock");
  AST_CLK6_IO_DIR: assert property (general_io_pin_enable_in[GP_CLK6_BIT] |=>
      clk_pad_oe_out[1] == $past(general_io_pin_direction_in[GP_CLK6_BIT]))
    else $error("io direction not applied to cpu/6 pin");
  AST_IO_OWNS_CLK4: assert property (general_io_pin_enable_in[GP_CLK4_BIT]
      && general_io_pin_direction_in[GP_CLK4_BIT]
      |=> clk_pad_out[0] == $past(general_io_bank_in[GP_CLK4_BIT]))
    else $error("io bit 1 does not drive its pin");
  AST_DAC_GATED: assert property (parallel_bus_enabled_out && cfg.locked |=>
      dac_pad_oe_out && dac_pad_out == $past(video_dac_output_in))
    else $error("io bit 8 took dac pin with bus on");
  AST_DAC_DEFAULT: assert property (!general_io_pin_enable_in[GP_DAC_BIT] |=>
      dac_pad_oe_out && dac_pad_out == $past(video_dac_output_in))
    else $error("dac pin not on dac output");
  AST_BUS_OWNS: assert property (parallel_bus_enabled_out && cfg.locked |=>
      pbus_pad_oe_out == $past(pbus_shared_oe_in) && pbus_pad_out == $past(pbus_shared_data_in))
    else $error("bus-shared pins not owned by bus");
  AST_IO_BUS_PINS: assert property (!parallel_bus_enabled_out && cfg.locked |=>
      pbus_pad_oe_out == $past(general_io_pin_enable_in[GP_PBUS_MSB:GP_PBUS_LSB]
                               & general_io_pin_direction_in[GP_PBUS_MSB:GP_PBUS_LSB]))
    else $error("io bits 9-15 not driving per enable");
  AST_DED_HIZ: assert property (!parallel_bus_enabled_out |=> pbus_ded_pad_oe_out == '0)
    else $error("dedicated bus pin driven while bus off");
  AST_VIDEO_ROUTE: assert property (video_port1_enable_in |=>
      av_pad_oe_out == $past(video_port1_data_oe_in) && audio_serial0_data_lines_out == '0)
    else $error("video port 1 not routed");
  AST_AUDIO_ROUTE: assert property (audio_serial0_enable_in && !video_port1_enable_in |=>
      av_pad_out == $past(audio_serial0_data_lines_in) && video_port1_data_out == '0)
    else $error("audio data lines not routed");
  AST_AV_IDLE: assert property (!video_port1_enable_in && !audio_serial0_enable_in |=>
      av_pad_oe_out == '0 && av_pad_out == '0)
    else $error("idle shared pins driven");
  AST_BUS_FROZEN: assert property (cfg.locked |=> $stable(parallel_bus_enabled_out))
    else $error("bus selection changed after lock");

  COV_BUS_ON: cover property (cfg.locked && parallel_bus_enabled_out);
  COV_IO8_OUT: cover property (!parallel_bus_enabled_out && cfg.locked && dac_pad_oe_out
                               && general_io_pin_enable_in[GP_DAC_BIT]);
  COV_VIDEO: cover property (video_port1_enable_in ##1 av_pad_oe_out != '0);
  COV_AUDIO: cover property (au_sel ##1 audio_serial0_data_lines_out != '0);
endmodule : spfs_pin_select

// *** dv/spfs_pin_select_tb_top.sv ***
// self-checking testbench for the shared pin function select block
`timescale 1ns/100ps
module spfs_pin_select_tb_top
  import spfs_pkg::*;
;
  localparam int LIMIT = 600;
  logic                     clk_in, rst_n_in, strap, vp1_en, as0_en, c4, c6, dac, dac_pad_i;
  logic [GP_W-1:0]          en, dir, bank, bank_o;
  logic [PBUS_SHARED_W-1:0] psd, psoe, ps_rx, pb_pad_i, pb_o, pb_oe;
  logic [PBUS_DED_W-1:0]    pdd, pdoe, ded_o, ded_oe;
  logic [AV_W-1:0]          vd, voe, vid_o, ad, aoe, aud_o, av_pad_i, av_o, av_oe;
  logic [CLK_PIN_W-1:0]     clk_pad_i, clk_o, clk_oe;
  logic                     dac_o, dac_oe, bus_en;
  logic [AV_W-1:0]          exp_oe;
  int                       err_count, n_tests, cyc;

  spfs_pin_select i_spfs_pin_select (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .pbus_enable_strap_in(strap),
    .general_io_pin_enable_in(en), .general_io_pin_direction_in(dir),
    .general_io_bank_in(bank), .general_io_bank_out(bank_o),
    .video_port1_enable_in(vp1_en), .audio_serial0_enable_in(as0_en),
    .cpu_div4_clock_in(c4), .cpu_div6_clock_in(c6), .video_dac_output_in(dac),
    .pbus_shared_data_in(psd), .pbus_shared_oe_in(psoe), .pbus_shared_rx_out(ps_rx),
    .pbus_ded_data_in(pdd), .pbus_ded_oe_in(pdoe),
    .video_port1_data_in(vd), .video_port1_data_oe_in(voe), .video_port1_data_out(vid_o),
    .audio_serial0_data_lines_in(ad), .audio_serial0_data_lines_oe_in(aoe),
    .audio_serial0_data_lines_out(aud_o),
    .clk_pad_in(clk_pad_i), .clk_pad_out(clk_o), .clk_pad_oe_out(clk_oe),
    .dac_pad_in(dac_pad_i), .dac_pad_out(dac_o), .dac_pad_oe_out(dac_oe),
    .pbus_pad_in(pb_pad_i), .pbus_pad_out(pb_o), .pbus_pad_oe_out(pb_oe),
    .av_pad_in(av_pad_i), .av_pad_out(av_o), .av_pad_oe_out(av_oe),
    .pbus_ded_pad_out(ded_o), .pbus_ded_pad_oe_out(ded_oe),
    .parallel_bus_enabled_out(bus_en)
  );

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // inputs move 1 ns after the edge so the design never races the bench
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_end(input string name);
    $display("test %s done, mismatches so far %0d", name, err_count);
  endtask : test_end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  // hang guard: the whole run needs about 60 cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      $display("BAD timeout expected finish seen hang");
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_in  = 1'b0;
    strap     = 1'b0;
    vp1_en    = 1'b0;
    as0_en    = 1'b0;
    c4        = 1'b1;
    c6        = 1'b0;
    dac       = 1'b1;
    dac_pad_i = 1'b0;
    en        = 16'h0000;
    dir       = 16'h0000;
    bank      = 16'h0000;
    psd       = 7'h2a;
    psoe      = 7'h7f;
    pb_pad_i  = 7'h00;
    pdd       = 8'h5a;
    pdoe      = 8'hff;
    vd        = 8'ha5;
    voe       = 8'hff;
    ad        = 8'h3c;
    aoe       = 8'hf0;
    av_pad_i  = 8'h96;
    clk_pad_i = 2'b00;
    err_count = 0;
    n_tests   = 0;
    cyc       = 0;
    step(20);
    chk("clk_oe_rst", clk_oe, 2'b11);
    chk("dac_oe_rst", dac_oe, 1'b1);
    chk("av_oe_rst", av_oe, 8'h00);
    chk("pb_oe_rst", pb_oe, 7'h00);
    chk("ded_oe_rst", ded_oe, 8'h00);
    rst_n_in = 1'b1;
    step(4);
    chk("bus_en_dflt", bus_en, PBUS_EN_RST);
    chk("clk_out_a", clk_o, 2'b01);
    c4 = 1'b0;
    c6 = 1'b1;
    step(1);
    chk("clk_out_b", clk_o, 2'b10);
    chk("dac_out", {dac_oe, dac_o}, 2'b11);
    chk("ded_oe_off", ded_oe, 8'h00);
    test_end("defaults");

    // io1 output, io2 input on the clock pins
    en        = 16'h0006;
    dir       = 16'h0002;
    bank      = 16'h0002;
    clk_pad_i = 2'b11;
    step(1);
    chk("clk_oe_io", clk_oe, 2'b01);
    chk("clk_out_io", clk_o[0], 1'b1);
    step(2);
    chk("bank_in_clk", bank_o, 16'h0004);
    test_end("clock_pins_io");

    // io8..15 with the bus off: odd bits out, even bits in
    en        = 16'hff00;
    dir       = 16'haa00;
    bank      = 16'hffff;
    dac_pad_i = 1'b1;
    pb_pad_i  = 7'h7f;
    step(1);
    chk("clk_oe_back", clk_oe, 2'b11);
    chk("dac_oe_io_in", dac_oe, 1'b0);
    chk("pb_oe_io", pb_oe, 7'h55);
    chk("pb_out_io", pb_o & pb_oe, 7'h55);
    chk("ded_oe_off2", ded_oe, 8'h00);
    step(2);
    chk("bank_in_hi", bank_o, 16'h5500);
    test_end("bus_pins_io");

    // none, video, audio, both
    for (int m = 0; m < 4; m++) begin
      vp1_en = m[0];
      as0_en = m[1];
      exp_oe = (m == 0) ? 8'h00 : (m[0] ? voe : aoe);
      step(1);
      chk("av_oe", av_oe, exp_oe);
      chk("av_out", av_o & av_oe, (m[0] ? vd : ad) & exp_oe);
      step(2);
      chk("vid_rx", vid_o, m[0] ? av_pad_i : 8'h00);
      chk("aud_rx", aud_o, (m == 2) ? av_pad_i : 8'h00);
    end
    test_end("video_audio");

    // bus strapped on, then strap pin moves after lock
    strap = 1'b1;
    rst_n_in = 1'b0;
    step(2);
    rst_n_in = 1'b1;
    // strap not yet latched: the bus must own nothing
    step(2);
    chk("bus_en_prelock", bus_en, 1'b0);
    chk("pb_oe_prelock", pb_oe, 7'h00);
    chk("ded_oe_prelock", ded_oe, 8'h00);
    step(2);
    chk("bus_en_on", bus_en, 1'b1);
    strap    = 1'b0;
    pb_pad_i = 7'h33;
    dac      = 1'b0;
    step(5);
    chk("bus_en_held", bus_en, 1'b1);
    chk("dac_keep", {dac_oe, dac_o}, 2'b10);
    chk("pb_oe_bus", pb_oe, 7'h7f);
    chk("pb_out_bus", pb_o, 7'h2a);
    chk("ded_bus", {ded_oe, ded_o}, 16'hff5a);
    chk("pb_rx_bus", ps_rx, 7'h33);
    chk("bank_hi_bus", bank_o[15:8], 8'h00);
    test_end("bus_on");
    summarize();
  end
endmodule : spfs_pin_select_tb_top
